/* switch_scan_pkg.sv */
// constants, field layouts, timing tables and carriers for the scan configuration checker
package switch_scan_pkg;

	// channel counts
	localparam int NUM_INPUTS  = 24;
	localparam int NUM_WC_SLOTS = 15;
	localparam int WC_W        = 3;
	localparam int SLOTS_PER_A = 8;
	localparam int COUNT_W     = 5;

	// grid scan field layout and codes
	localparam int GRID_MODE_LSB = 3;
	localparam int GRID_WIN_LSB  = 0;
	localparam logic [1:0] GRID_OFF = 2'h0;
	localparam logic [1:0] GRID_4X4 = 2'h1;
	localparam logic [1:0] GRID_5X5 = 2'h2;
	localparam logic [1:0] GRID_6X6 = 2'h3;

	// row (sink) and column (source) input masks per grid size
	localparam logic [23:0] ROWS_4X4 = 24'h00_00F0;
	localparam logic [23:0] ROWS_5X5 = 24'h00_01F0;
	localparam logic [23:0] ROWS_6X6 = 24'h00_03F0;
	localparam logic [23:0] COLS_4X4 = 24'h00_3C00;
	localparam logic [23:0] COLS_5X5 = 24'h00_7C00;
	localparam logic [23:0] COLS_6X6 = 24'h00_FC00;

	// device configuration word fields
	localparam int CFG_PERIOD_LSB = 1;
	localparam int CFG_ACT_LSB    = 5;
	localparam int CFG_SUPPLY_BIT = 16;
	localparam int CFG_DIAG_LSB   = 18;

	// wetting current configuration fields
	localparam int PAIR1_SRC_LSB = 18;
	localparam int PAIR1_SNK_LSB = 6;
	localparam int PAIR2_SRC_LSB = 21;
	localparam int PAIR2_SNK_LSB = 9;
	localparam int PAIR3_SRC_LSB = 12;
	localparam int PAIR3_SNK_LSB = 0;
	localparam int PAIR4_SRC_LSB = 15;
	localparam int PAIR4_SNK_LSB = 3;
	localparam int AUTOSCALE_LSB = 21;
	localparam logic [1:0] AUTOSCALE_OFF = 2'h3;
	localparam logic [2:0] WC_1MA       = 3'h1;
	localparam logic [2:0] WC_2MA       = 3'h2;
	localparam logic [2:0] WC_SCALE_MIN = 3'h4;

	// diagnostic input layout
	localparam logic [3:0] DIAG_ADC_ALL  = 4'hF;
	localparam logic [1:0] DIAG_SRC_SEL  = 2'h0;
	localparam logic [1:0] DIAG_SNK_SEL  = 2'h3;
	localparam int QUIET_DUR_LSB = 4;

	// sampling budget terms: 13/10 margin ratio, times in microseconds, grid window counts
	localparam int unsigned BUDGET_NUM = 13;
	localparam int unsigned BUDGET_DEN = 10;
	localparam int unsigned CHAN_US    = 24;
	localparam int unsigned FIXED_US   = 10;
	localparam int unsigned DIAG_US    = 96;
	localparam int unsigned QUIET_TRAN_US = 10;
	localparam int unsigned GRID_M_4X4 = 16;
	localparam int unsigned GRID_M_5X5 = 25;
	localparam int unsigned GRID_M_6X6 = 36;

	// code to time tables in microseconds
	localparam int unsigned POLL_TIME_US [16] = '{1000, 2000, 4000, 8000, 16000, 32000,
		64000, 128000, 256000, 512000, 1024000, 2048000, 4096000, 8192000, 16384000,
		32768000};
	localparam int unsigned ACT_TIME_US [16] = '{16, 32, 48, 64, 80, 96, 112, 128, 144,
		160, 176, 192, 208, 224, 240, 256};
	localparam int unsigned GRID_ACT_US [8] = '{16, 32, 48, 64, 80, 96, 112, 128};
	localparam int unsigned QUIET_DUR_US [8] = '{8, 16, 24, 32, 40, 48, 56, 64};

	// configuration fields as programmed by the host
	typedef struct packed {
		logic        periodic_enable;
		logic [23:0] in_en;
		logic [23:0] adc_mode;
		logic [23:0] sink_select;
		logic [23:0] wetting_current_cfg_a;
		logic [23:0] wetting_current_cfg_b;
		logic [21:0] device_cfg;
		logic [4:0]  grid_scan;
		logic [6:0]  quiet_sampling_cfg_a;
		logic [23:0] quiet_sampling_cfg_b;
		logic        temp_warning_expected;
	} scan_cfg_s;

	// violation indications
	typedef struct packed {
		logic grid_setup;
		logic grid_current;
		logic temp_warning;
		logic diag_setup;
		logic period_short;
	} violation_s;

	// count of set bits in an input mask
	function automatic logic [COUNT_W-1:0] count_ones(input logic [23:0] v);
		logic [COUNT_W-1:0] c;
		c = '0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			c = c + COUNT_W'(v[i]);
		end
		return c;
	endfunction : count_ones

endpackage : switch_scan_pkg

/* period_budget_check.sv */
// minimum sampling period check against the active window budget
`timescale 1ns/1ps
module period_budget_check (
	input  wire logic [3:0]  period_code,
	input  wire logic [3:0]  act_code,
	input  wire logic [2:0]  grid_win_code,
	input  wire logic [1:0]  grid_mode,
	input  wire logic [4:0]  enabled_count,
	input  wire logic        diag_on,
	input  wire logic        quiet_on,
	input  wire logic [2:0]  quiet_dur_code,
	output logic             period_short
);
	int unsigned m_count;
	int unsigned budget_us;
	int unsigned lhs;
	int unsigned rhs;

	// sum the budget and compare period against 1.3 times it
	always_comb begin
		case (grid_mode)
			switch_scan_pkg::GRID_4X4: m_count = switch_scan_pkg::GRID_M_4X4;
			switch_scan_pkg::GRID_5X5: m_count = switch_scan_pkg::GRID_M_5X5;
			switch_scan_pkg::GRID_6X6: m_count = switch_scan_pkg::GRID_M_6X6;
			default:                   m_count = 0;
		endcase
		// R10: normal window budget
		budget_us = switch_scan_pkg::ACT_TIME_US[act_code]
			+ 32'(enabled_count) * switch_scan_pkg::CHAN_US + switch_scan_pkg::FIXED_US;
		// R11: grid windows added
		budget_us = budget_us + m_count * switch_scan_pkg::GRID_ACT_US[grid_win_code];
		// R13: diagnostic extra time
		if (diag_on) begin
			budget_us = budget_us + switch_scan_pkg::DIAG_US;
		end
		// R14: quiet sampling time
		if (quiet_on) begin
			budget_us = budget_us + switch_scan_pkg::QUIET_TRAN_US
				+ switch_scan_pkg::QUIET_DUR_US[quiet_dur_code];
		end
		// R12: period from its code
		lhs = switch_scan_pkg::POLL_TIME_US[period_code] * switch_scan_pkg::BUDGET_DEN;
		rhs = budget_us * switch_scan_pkg::BUDGET_NUM;
		// R11: strict margin in grid scan
		if (grid_mode != switch_scan_pkg::GRID_OFF) begin
			period_short = (lhs <= rhs);
		end else begin
			period_short = (lhs < rhs);
		end
	end

endmodule : period_budget_check

/* switch_scan_config_checker.sv */
// configuration consistency checker for the switch monitor scan modes
`timescale 1ns/1ps
// Contract
// R1: 5x5 grid needs periodic, rows sink, columns source
// R2: 6x6 grid needs periodic, rows sink, columns source
// R3: grid sink current above paired source current
// R4: temperature warning limits source to 1 or 2 mA
// R5: quiet sampling needs an input or supply measure
// R6: auto-scaling only if enabled and continuous mode
// R7: auto-scaling only for 10 or 15 mA codes
// R8: diagnostic needs one of inputs 0-3 enabled
// R9: diagnostic needs ADC mode, 0-1 source, 2-3 sink
// R10: period at least 1.3 times normal budget
// R11: grid period exceeds 1.3 times grid budget
// R12: timing codes taken from their fixed fields
// R13: diagnostic adds 96 us to budget
// R14: quiet sampling adds transition plus duration
// R15: grid mode code 01 selects 4x4 scan
// R16: re-check on every write, flag violations
module switch_scan_config_checker (
	input  wire logic                          clk,
	input  wire logic                          nrst,
	input  wire logic                          cfg_write,
	input  wire switch_scan_pkg::scan_cfg_s    cfg,
	output switch_scan_pkg::violation_s        violation_flags,
	output logic                               violation,
	output logic [1:0]                         grid_size,
	output logic                               quiet_sampling_effective,
	output logic                               autoscale_active,
	output logic [14:0]                        autoscale_mask
);
	// pair check: sink above source, and source limited under temperature warning
	function automatic logic [1:0] pair_bad(input logic [2:0] src, input logic [2:0] snk,
		input logic tw);
		logic order_bad;
		logic tw_bad;
		order_bad = !(snk > src);
		tw_bad    = tw && !(((src == switch_scan_pkg::WC_1MA) && (snk >= switch_scan_pkg::WC_2MA))
			|| ((src == switch_scan_pkg::WC_2MA) && (snk > switch_scan_pkg::WC_2MA)));
		return {tw_bad, order_bad};
	endfunction : pair_bad

	// wetting current code of a channel slot
	function automatic logic [2:0] slot_code(input logic [23:0] a, input logic [23:0] b,
		input int s);
		if (s < switch_scan_pkg::SLOTS_PER_A) begin
			return a[s*switch_scan_pkg::WC_W +: switch_scan_pkg::WC_W];
		end else begin
			return b[(s-switch_scan_pkg::SLOTS_PER_A)*switch_scan_pkg::WC_W +: switch_scan_pkg::WC_W];
		end
	endfunction : slot_code

	logic [1:0]  grid_mode;
	logic [23:0] rows;
	logic [23:0] cols;
	logic [1:0]  p1;
	logic [1:0]  p2;
	logic [1:0]  p3;
	logic [1:0]  p4;
	logic        diag_on;
	logic        quiet_on;
	logic        period_short;
	logic [4:0]  enabled_count;
	switch_scan_pkg::violation_s flags_next;
	logic        quiet_next;
	logic        autoscale_next;
	logic [14:0] mask_next;

	// R12: field extraction
	assign grid_mode = cfg.grid_scan[switch_scan_pkg::GRID_MODE_LSB +: 2];
	assign diag_on   = cfg.device_cfg[switch_scan_pkg::CFG_DIAG_LSB +: 4] != 4'h0;
	assign quiet_on  = cfg.quiet_sampling_cfg_b != 24'h00_0000;
	assign enabled_count = switch_scan_pkg::count_ones(cfg.in_en);

	// budget comparator
	period_budget_check u_budget (
		.period_code    (cfg.device_cfg[switch_scan_pkg::CFG_PERIOD_LSB +: 4]),
		.act_code       (cfg.device_cfg[switch_scan_pkg::CFG_ACT_LSB +: 4]),
		.grid_win_code  (cfg.grid_scan[switch_scan_pkg::GRID_WIN_LSB +: 3]),
		.grid_mode      (grid_mode),
		.enabled_count  (enabled_count),
		.diag_on        (diag_on),
		.quiet_on       (quiet_on),
		.quiet_dur_code (cfg.quiet_sampling_cfg_a[switch_scan_pkg::QUIET_DUR_LSB +: 3]),
		.period_short   (period_short)
	);

	// evaluate every precondition on the current fields
	always_comb begin
		// R15: grid size masks
		case (grid_mode)
			switch_scan_pkg::GRID_4X4: begin
				rows = switch_scan_pkg::ROWS_4X4;
				cols = switch_scan_pkg::COLS_4X4;
			end
			switch_scan_pkg::GRID_5X5: begin
				rows = switch_scan_pkg::ROWS_5X5;
				cols = switch_scan_pkg::COLS_5X5;
			end
			switch_scan_pkg::GRID_6X6: begin
				rows = switch_scan_pkg::ROWS_6X6;
				cols = switch_scan_pkg::COLS_6X6;
			end
			default: begin
				rows = 24'h00_0000;
				cols = 24'h00_0000;
			end
		endcase
		// R1: R2: grid pin setup
		flags_next.grid_setup = (grid_mode != switch_scan_pkg::GRID_OFF)
			&& !(cfg.periodic_enable && ((cfg.in_en & (rows | cols)) == (rows | cols))
			&& ((cfg.adc_mode & (rows | cols)) == 24'h00_0000)
			&& ((cfg.sink_select & rows) == rows) && ((cfg.sink_select & cols) == 24'h00_0000));
		// R3: R4: paired current codes
		p1 = pair_bad(cfg.wetting_current_cfg_a[switch_scan_pkg::PAIR1_SRC_LSB +: 3],
			cfg.wetting_current_cfg_a[switch_scan_pkg::PAIR1_SNK_LSB +: 3], cfg.temp_warning_expected);
		p2 = pair_bad(cfg.wetting_current_cfg_a[switch_scan_pkg::PAIR2_SRC_LSB +: 3],
			cfg.wetting_current_cfg_a[switch_scan_pkg::PAIR2_SNK_LSB +: 3], cfg.temp_warning_expected);
		p3 = pair_bad(cfg.wetting_current_cfg_a[switch_scan_pkg::PAIR3_SRC_LSB +: 3],
			cfg.wetting_current_cfg_b[switch_scan_pkg::PAIR3_SNK_LSB +: 3], cfg.temp_warning_expected);
		p4 = pair_bad(cfg.wetting_current_cfg_a[switch_scan_pkg::PAIR4_SRC_LSB +: 3],
			cfg.wetting_current_cfg_b[switch_scan_pkg::PAIR4_SNK_LSB +: 3], cfg.temp_warning_expected);
		if (grid_mode == switch_scan_pkg::GRID_OFF) begin
			flags_next.grid_current = 1'b0;
			flags_next.temp_warning = 1'b0;
		end else if (grid_mode == switch_scan_pkg::GRID_4X4) begin
			flags_next.grid_current = p1[0] | p2[0] | p3[0];
			flags_next.temp_warning = p1[1] | p2[1] | p3[1];
		end else begin
			flags_next.grid_current = p1[0] | p2[0] | p3[0] | p4[0];
			flags_next.temp_warning = p1[1] | p2[1] | p3[1] | p4[1];
		end
		// R8: R9: diagnostic input setup
		flags_next.diag_setup = diag_on && ((cfg.in_en[3:0] == 4'h0)
			|| (cfg.adc_mode[3:0] != switch_scan_pkg::DIAG_ADC_ALL)
			|| (cfg.sink_select[1:0] != switch_scan_pkg::DIAG_SRC_SEL)
			|| (cfg.sink_select[3:2] != switch_scan_pkg::DIAG_SNK_SEL));
		// R10: R11: period budget
		flags_next.period_short = period_short;
		// R5: quiet sampling takes effect
		quiet_next = quiet_on && ((cfg.in_en != 24'h00_0000)
			|| cfg.device_cfg[switch_scan_pkg::CFG_SUPPLY_BIT]);
		// R6: auto-scaling gate
		autoscale_next = (cfg.wetting_current_cfg_b[switch_scan_pkg::AUTOSCALE_LSB +: 2]
			!= switch_scan_pkg::AUTOSCALE_OFF) && !cfg.periodic_enable;
		// R7: per-slot scaling for high codes
		for (int s = 0; s < switch_scan_pkg::NUM_WC_SLOTS; s++) begin
			mask_next[s] = autoscale_next && (slot_code(cfg.wetting_current_cfg_a,
				cfg.wetting_current_cfg_b, s) >= switch_scan_pkg::WC_SCALE_MIN);
		end
	end

	// R16: capture results on each write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			violation_flags <= '0;
			violation       <= 1'b0;
		end else if (cfg_write) begin
			violation_flags <= flags_next;
			violation       <= |flags_next;
		end
	end

	// feature status captured on each write
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			grid_size                <= 2'h0;
			quiet_sampling_effective <= 1'b0;
			autoscale_active         <= 1'b0;
			autoscale_mask           <= 15'h0000;
		end else if (cfg_write) begin
			grid_size                <= grid_mode;
			quiet_sampling_effective <= quiet_next;
			autoscale_active         <= autoscale_next;
			autoscale_mask           <= mask_next;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	grid_periodic_a: assert property (cfg_write && grid_mode == switch_scan_pkg::GRID_5X5 // R1
		&& !cfg.periodic_enable |=> violation_flags.grid_setup && violation)
		else $error("5x5 grid without periodic sampling not flagged");
	grid_six_pins_a: assert property (cfg_write && grid_mode == switch_scan_pkg::GRID_6X6 // R2
		&& !cfg.in_en[15] |=> violation_flags.grid_setup)
		else $error("6x6 grid with column input off not flagged");
	current_order_a: assert property (cfg_write && grid_mode != switch_scan_pkg::GRID_OFF // R3
		&& cfg.wetting_current_cfg_a[20:18] >= cfg.wetting_current_cfg_a[8:6]
		|=> violation_flags.grid_current)
		else $error("sink current not above source current but not flagged");
	temp_limit_a: assert property (cfg_write && grid_mode != switch_scan_pkg::GRID_OFF // R4
		&& cfg.temp_warning_expected && cfg.wetting_current_cfg_a[20:18] > 3'h2
		|=> violation_flags.temp_warning)
		else $error("source current above 2 mA under warning not flagged");
	quiet_effect_a: assert property (cfg_write && cfg.in_en == 24'h00_0000 // R5
		&& !cfg.device_cfg[16] |=> !quiet_sampling_effective)
		else $error("quiet sampling effective with nothing enabled");
	autoscale_mode_a: assert property (cfg_write && cfg.periodic_enable // R6
		|=> !autoscale_active && autoscale_mask == 15'h0000)
		else $error("auto-scaling active in periodic mode");
	autoscale_code_a: assert property (cfg_write && !cfg.periodic_enable // R7
		&& cfg.wetting_current_cfg_b[22:21] != 2'h3
		|=> autoscale_mask[0] == $past(cfg.wetting_current_cfg_a[2]))
		else $error("auto-scaling mask disagrees with current code");
	diag_enable_a: assert property (cfg_write && diag_on && cfg.in_en[3:0] == 4'h0 // R8
		|=> violation_flags.diag_setup && violation)
		else $error("diagnostic without inputs 0-3 not flagged");
	diag_modes_a: assert property (cfg_write && diag_on && cfg.sink_select[3:2] != 2'h3 // R9
		|=> violation_flags.diag_setup)
		else $error("diagnostic sink selection wrong but not flagged");
	hold_between_a: assert property (!cfg_write // R16
		|=> $stable(violation_flags) && $stable(violation) && $stable(autoscale_mask))
		else $error("results changed without a configuration write");
	summary_flag_a: assert property (cfg_write |=> violation == (|violation_flags)) // R16
		else $error("violation summary disagrees with flags");
	grid_select_a: assert property (cfg_write && cfg.grid_scan[4:3] == 2'h1 // R15
		|=> grid_size == switch_scan_pkg::GRID_4X4)
		else $error("code 01 did not select 4x4 grid");

	grid_clean_c: cover property (cfg_write && grid_mode == switch_scan_pkg::GRID_6X6
		##1 !violation);
	autoscale_on_c: cover property (cfg_write ##1 autoscale_active && autoscale_mask != 15'h0000);
	period_short_c: cover property (cfg_write ##1 violation_flags.period_short);
	quiet_on_c: cover property (cfg_write ##1 quiet_sampling_effective);

endmodule : switch_scan_config_checker

/* host_cfg_model.sv */
// host model that programs the scan checker configuration fields
`timescale 1ns/1ps
module host_cfg_model (
	output switch_scan_pkg::scan_cfg_s cfg,
	output logic                       cfg_write
);
	// host outputs idle at power-up
	initial begin
		cfg = '0;
		cfg_write = 1'b0;
	end

	// present a configuration, repairing the fields picked in fix
	task automatic send(input switch_scan_pkg::scan_cfg_s c, input logic [3:0] fix,
		input logic wr);
		logic [23:0] rows;
		logic [23:0] both;
		rows = (c.grid_scan[4:3] == 2'h0) ? 24'h00_0000 :
			(((24'h00_0001 << (c.grid_scan[4:3] + 7)) - 24'h00_0001) & ~24'h00_000F);
		both = rows | (rows << 6);
		// periodic grid, rows sink, columns source, comparator mode
		if (fix[0]) begin
			c.periodic_enable = 1'b1;
			c.in_en = c.in_en | both;
			c.adc_mode = c.adc_mode & ~both;
			c.sink_select = (c.sink_select & ~both) | rows;
		end
		// every source 1 mA, every paired sink higher
		if (fix[1]) begin
			c.wetting_current_cfg_a[23:12] = {4{switch_scan_pkg::WC_1MA}};
			c.wetting_current_cfg_a[11:6] = {2{switch_scan_pkg::WC_2MA}};
			c.wetting_current_cfg_b[5:0] = {2{switch_scan_pkg::WC_2MA}};
		end
		// diagnostic input 0 enabled, inputs 0-3 in adc mode with fixed directions
		if (fix[2]) begin
			c.in_en[0] = 1'b1;
			c.adc_mode[3:0] = switch_scan_pkg::DIAG_ADC_ALL;
			c.sink_select[3:0] = {switch_scan_pkg::DIAG_SNK_SEL, switch_scan_pkg::DIAG_SRC_SEL};
		end
		if (fix[3]) begin
			c.device_cfg[4:1] = 4'hF;
		end
		cfg <= c;
		cfg_write <= wr;
	endtask : send
endmodule : host_cfg_model

/* switch_scan_config_checker_bench.sv */
// self-checking bench for the scan configuration checker
`timescale 1ns/1ps
module switch_scan_config_checker_bench;
	localparam int CFG_BITS = $bits(switch_scan_pkg::scan_cfg_s);
	logic                        clk;
	logic                        nrst;
	switch_scan_pkg::scan_cfg_s  cfg;
	logic                        cfg_write;
	switch_scan_pkg::violation_s violation_flags;
	logic                        violation;
	logic [1:0]                  grid_size;
	logic                        quiet_sampling_effective;
	logic                        autoscale_active;
	logic [14:0]                 autoscale_mask;
	int                          miscompares;
	int                          checked;
	logic [24:0]                 exp_out;
	logic                        pend;
	switch_scan_pkg::scan_cfg_s  c;

	host_cfg_model host (.cfg(cfg), .cfg_write(cfg_write));

	switch_scan_config_checker dut (.clk(clk), .nrst(nrst), .cfg_write(cfg_write), .cfg(cfg),
		.violation_flags(violation_flags), .violation(violation), .grid_size(grid_size),
		.quiet_sampling_effective(quiet_sampling_effective),
		.autoscale_active(autoscale_active), .autoscale_mask(autoscale_mask));

	// free-running clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// whole configuration drawn at random
	function automatic switch_scan_pkg::scan_cfg_s rand_cfg();
		logic [223:0] r;
		for (int i = 0; i < 7; i++) r[i*32 +: 32] = $urandom();
		return switch_scan_pkg::scan_cfg_s'(r[CFG_BITS-1:0]);
	endfunction : rand_cfg

	// expected flags, violation, grid size, quiet, autoscale and mask
	function automatic logic [24:0] expect_out(input switch_scan_pkg::scan_cfg_s v);
		logic [1:0]  g;
		logic [23:0] rw;
		logic [23:0] bo;
		logic [23:0] a;
		logic [23:0] b;
		logic [2:0]  s [4];
		logic [2:0]  k [4];
		logic [4:0]  f;
		logic [14:0] m;
		logic [2:0]  code;
		logic        d;
		logic        act;
		int unsigned bud;
		int unsigned mm;
		int unsigned poll;
		g = v.grid_scan[4:3];
		a = v.wetting_current_cfg_a;
		b = v.wetting_current_cfg_b;
		rw = (g == 2'h0) ? 24'h00_0000 : (((24'h00_0001 << (g + 7)) - 24'h00_0001) & ~24'h00_000F);
		bo = rw | (rw << 6);
		s = '{a[20:18], a[23:21], a[14:12], a[17:15]};
		k = '{a[8:6], a[11:9], b[2:0], b[5:3]};
		f = '0;
		f[4] = (g != 2'h0) && !(v.periodic_enable && ((v.in_en & bo) == bo)
			&& ((v.adc_mode & bo) == 24'h00_0000) && ((v.sink_select & bo) == rw));
		for (int i = 0; i < ((g > 2'h1) ? 4 : 3); i++) begin
			if (g != 2'h0 && s[i] >= k[i]) f[3] = 1'b1;
			if (g != 2'h0 && v.temp_warning_expected && !((s[i] == 3'h1 && k[i] >= 3'h2)
				|| (s[i] == 3'h2 && k[i] >= 3'h3))) f[2] = 1'b1;
		end
		d = (v.device_cfg[21:18] != 4'h0);
		f[1] = d && (v.in_en[3:0] == 4'h0 || v.adc_mode[3:0] != 4'hF
			|| v.sink_select[3:0] != 4'hC);
		mm = (g == 2'h0) ? 0 : (g == 2'h1) ? 16 : (g == 2'h2) ? 25 : 36;
		bud = 16 * (v.device_cfg[8:5] + 1) + 24 * $countones(v.in_en) + 10
			+ mm * 16 * (v.grid_scan[2:0] + 1) + (d ? 96 : 0)
			+ ((v.quiet_sampling_cfg_b != 24'h00_0000) ? 18 + 8 * v.quiet_sampling_cfg_a[6:4] : 0);
		poll = 32'h0000_03E8 << v.device_cfg[4:1];
		f[0] = (g != 2'h0) ? (10 * poll <= 13 * bud) : (10 * poll < 13 * bud);
		act = (b[22:21] != 2'h3) && !v.periodic_enable;
		for (int i = 0; i < 15; i++) begin
			if (i < 8) code = a[3*i +: 3];
			else code = b[3*(i-8) +: 3];
			m[i] = act && code >= 3'h4;
		end
		return {f, |f, g, (v.quiet_sampling_cfg_b != 24'h00_0000)
			&& (v.in_en != 24'h00_0000 || v.device_cfg[16]), act, m};
	endfunction : expect_out

	// compare the violation flag group
	task automatic check_flags(input string nm, input switch_scan_pkg::violation_s e,
		input switch_scan_pkg::violation_s g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask : check_flags

	// compare a plain bit vector
	task automatic check_bits(input string nm, input logic [14:0] e, input logic [14:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : check_bits

	// compare every output against the held expectation
	task automatic check_all();
		check_flags("violation_flags", exp_out[24:20], violation_flags);
		check_bits("violation", 15'(exp_out[19]), 15'(violation));
		check_bits("grid_size", 15'(exp_out[18:17]), 15'(grid_size));
		check_bits("quiet_effective", 15'(exp_out[16]), 15'(quiet_sampling_effective));
		check_bits("autoscale_active", 15'(exp_out[15]), 15'(autoscale_active));
		check_bits("autoscale_mask", exp_out[14:0], autoscale_mask);
	endtask : check_all

	// one write per cycle; the previous result is checked first
	task automatic write_cfg(input switch_scan_pkg::scan_cfg_s v, input logic [3:0] fix);
		@(negedge clk);
		if (pend) check_all();
		host.send(v, fix, 1'b1);
		@(posedge clk);
		#1;
		exp_out = expect_out(cfg);
		pend = 1'b1;
	endtask : write_cfg

	// check the last write and drop the write strobe
	task automatic flush();
		@(negedge clk);
		if (pend) check_all();
		pend = 1'b0;
		host.send(cfg, 4'h0, 1'b0);
	endtask : flush

	// hold reset ten cycles; all outputs must read zero
	task automatic do_reset();
		@(negedge clk);
		nrst = 1'b0;
		repeat (10) @(negedge clk);
		exp_out = '0;
		check_all();
		nrst = 1'b1;
	endtask : do_reset

	// print counts and the verdict, then stop
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		wrap_up();
	end

	// main sequence
	initial begin
		nrst = 1'b0;
		miscompares = 0;
		checked = 0;
		pend = 1'b0;
		exp_out = '0;
		void'($urandom(32'h49cf_5fc8));
		do_reset();
		// every grid code with each combination of host repairs
		for (int g = 0; g < 4; g++) begin
			for (int f = 0; f < 16; f++) begin
				c = rand_cfg();
				c.grid_scan[4:3] = 2'(g);
				write_cfg(c, 4'(15 - f));
			end
		end
		// period just long enough, then one channel too many
		for (int n = 20; n < 22; n++) begin
			c = '0;
			c.device_cfg[8:5] = 4'hF;
			c.in_en = (24'h00_0001 << n) - 24'h00_0001;
			write_cfg(c, 4'h0);
		end
		// quiet sampling with nothing enabled, then with supply measure on
		c = '0;
		c.quiet_sampling_cfg_b = 24'h00_0001;
		write_cfg(c, 4'h0);
		c.device_cfg[16] = 1'b1;
		write_cfg(c, 4'h0);
		repeat (300) write_cfg(rand_cfg(), 4'($urandom_range(0, 15)));
		flush();
		// changes without a write leave the results standing
		repeat (5) begin
			@(negedge clk);
			host.send(rand_cfg(), 4'h0, 1'b0);
			check_all();
		end
		do_reset();
		repeat (20) write_cfg(rand_cfg(), 4'($urandom_range(0, 15)));
		flush();
		wrap_up();
	end
endmodule : switch_scan_config_checker_bench
